// ===== logic/gpc_pin_drive.sv
/*
 * Output stage control of one pin: turns the drive mode, data and
 * bidirectional enable into driver, pull and input buffer enables.
 * Assumes all inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
module gpc_pin_drive (
    input wire logic [2:0] pin_drive_mode_bits,
    input wire logic data,
    input wire logic bie,
    input wire logic oe_dyn,
    input wire logic vreg,
    input wire logic ibd,
    input wire logic slw,
    output logic drv_o,
    output logic drv_oe,
    output logic pull_up,
    output logic pull_dn,
    output logic in_en,
    output logic slow
);
    logic [2:0] mode;

    // Drive table per mode; bidirectional off-state falls back to digital hi-Z
    always_comb begin
        mode = (bie && !oe_dyn) ? gpc_pkg::DM_HIZ_DIG : pin_drive_mode_bits;
        drv_o = data;
        drv_oe = 1'b0;
        pull_up = 1'b0;
        pull_dn = 1'b0;
        case (mode)
            gpc_pkg::DM_RES_UP: begin
                drv_oe = !data;
                pull_up = data;
            end
            gpc_pkg::DM_RES_DN: begin
                drv_oe = data;
                pull_dn = !data;
            end
            gpc_pkg::DM_OD_LO: drv_oe = !data;
            gpc_pkg::DM_OD_HI: drv_oe = data;
            gpc_pkg::DM_STRONG: drv_oe = 1'b1;
            gpc_pkg::DM_RES_BOTH: begin
                pull_up = data;
                pull_dn = !data;
            end
            default: drv_oe = 1'b0;
        endcase
        // Regulated high level cannot coexist with the resistive pulls
        if (vreg) begin
            pull_up = 1'b0;
            pull_dn = 1'b0;
        end
        // Analog hi-Z keeps the buffer off to avoid float current
        in_en = (mode != gpc_pkg::DM_HIZ_ANA) && !ibd;
        // Slow edges only make sense where a strong driver switches
        slow = slw && (mode == gpc_pkg::DM_OD_LO || mode == gpc_pkg::DM_OD_HI ||
                       mode == gpc_pkg::DM_STRONG);
    end

endmodule // gpc_pin_drive

// ===== logic/gpc_pkg.sv
/*
 * Shared constants of the eight-pin port control block: register byte
 * offsets, field positions, reset values and drive mode codes.
 * Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
 */
package gpc_pkg;

    // Port geometry
    localparam int PINS = 8;
    localparam int AUX_OE_W = 16;
    localparam int AUX_SEL_W = 4;
    localparam int SIO_PAIRS = 4;
    localparam int ADDR_W = 8;

    // Register byte offsets, port form
    localparam logic [7:0] OFS_OUT = 8'h00;
    localparam logic [7:0] OFS_DM0 = 8'h04;
    localparam logic [7:0] OFS_DM1 = 8'h08;
    localparam logic [7:0] OFS_DM2 = 8'h0C;
    localparam logic [7:0] OFS_SLW = 8'h10;
    localparam logic [7:0] OFS_BYP = 8'h14;
    localparam logic [7:0] OFS_BIE = 8'h18;
    localparam logic [7:0] OFS_IBD = 8'h1C;
    localparam logic [7:0] OFS_CTL = 8'h20;
    localparam logic [7:0] OFS_VREG = 8'h24;
    localparam logic [7:0] OFS_REF = 8'h28;
    localparam logic [7:0] OFS_ITYPE = 8'h2C;
    localparam logic [7:0] OFS_ISTAT = 8'h30;
    localparam logic [7:0] OFS_PSTATE = 8'h34;
    localparam logic [7:0] OFS_OESEL = 8'h38;
    localparam logic [7:0] OFS_RSTCFG = 8'h3C;
    // Pin form: one word per pin from here, 0x40..0x5C
    localparam logic [7:0] OFS_PIN_BASE = 8'h40;

    // Field positions
    localparam int CTL_LVTTL_BIT = 0;
    localparam int CTL_HYST_BIT = 1;
    localparam int REF_CMP_LSB = 8;
    localparam int PF_OUT_BIT = 0;
    localparam int PF_STATE_BIT = 1;
    localparam int PF_DM_LSB = 2;
    localparam int PF_SLW_BIT = 5;
    localparam int PF_BYP_BIT = 6;
    localparam int PF_BIE_BIT = 7;
    localparam int IT_RISE_BIT = 0;
    localparam int IT_FALL_BIT = 1;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam logic [15:0] RST_ITYPE = 16'h0000;
    localparam logic [31:0] RST_OESEL = 32'h0000_0000;
    localparam logic [11:0] RST_REF = 12'h000;

    // Nonvolatile reset configuration codes
    localparam logic [1:0] RCFG_HIZ = 2'h0;
    localparam logic [1:0] RCFG_PULLUP = 2'h1;
    localparam logic [1:0] RCFG_PULLDN = 2'h2;

    // Drive mode codes
    localparam logic [2:0] DM_HIZ_ANA = 3'h0;
    localparam logic [2:0] DM_HIZ_DIG = 3'h1;
    localparam logic [2:0] DM_RES_UP = 3'h2;
    localparam logic [2:0] DM_RES_DN = 3'h3;
    localparam logic [2:0] DM_OD_LO = 3'h4;
    localparam logic [2:0] DM_OD_HI = 3'h5;
    localparam logic [2:0] DM_STRONG = 3'h6;
    localparam logic [2:0] DM_RES_BOTH = 3'h7;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== logic/gpc_port.sv
/*
 * Eight-pin I/O port control: AXI4-Lite register file in port and pin
 * form, per-pin drive stages, edge interrupt unit, reset configuration.
 * Assumes clk and rst_n come from the system; pin_in is asynchronous;
 * aux_oe and dsi_out come from logic on clk; nv_rst_cfg is static.
 */
`timescale 1ns/1ps
module gpc_port #(
    parameter bit SIO_PORT = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic [7:0] pin_pull_up,
    output logic [7:0] pin_pull_dn,
    output logic [7:0] pin_in_en,
    output logic [7:0] pin_slew_select,
    output logic [7:0] pin_vreg_en,
    output logic port_lvttl,
    output logic sio_hyst_en,
    output logic [7:0] sio_ref_sel,
    output logic [3:0] sio_cmp_en,
    input wire logic [15:0] aux_oe,
    input wire logic [7:0] dsi_out,
    output logic [7:0] dsi_in,
    input wire logic [1:0] nv_rst_cfg,
    output logic port_irq
);
    // Configuration state
    logic [7:0] port_output_value_r, dm0_r, dm1_r, dm2_r;
    logic [7:0] slw_r, byp_r, bie_r, ibd_r, vreg_r;
    logic lvttl_r, hyst_r;
    logic [11:0] ref_r;
    logic [15:0] itype_r;
    logic [31:0] oesel_r;
    logic [1:0] rst_cfg_r;
    logic ld_done_r;
    // Interrupt unit state
    logic [7:0] pin_s1_r, pin_s2_r, pin_prev_r, istat_r;
    logic [7:0] edge_set;
    // Bus state
    logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
    logic [7:0] waddr_r;
    logic [31:0] wdata_r, rdata_r, rd_val;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;
    logic do_wr, wr_pin, rd_hit;
    logic [31:0] wmask;
    logic [7:0] wd8, wm8, istat_clr;
    logic [2:0] wpin;

    // Map check shared by the read decode and the write response
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a[7:5] == gpc_pkg::OFS_PIN_BASE[7:5]) ||
                   (a <= gpc_pkg::OFS_RSTCFG);
        addr_hit = addr_hit && (a[1:0] == 2'h0);
    endfunction

    // AXI4-Lite handshakes: one write and one read outstanding at most
    assign s_axi_awready = !aw_got_r && !bvalid_r;
    assign s_axi_wready = !w_got_r && !bvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign do_wr = aw_got_r && w_got_r && !bvalid_r;

    // Write channel capture; address and data may arrive in either order
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= gpc_pkg::RESP_OKAY;
            waddr_r <= 8'h00;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                waddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= addr_hit(waddr_r) ? gpc_pkg::RESP_OKAY : gpc_pkg::RESP_SLVERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Read channel: data registered at the edge that takes the address, valid from the next cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= gpc_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_val;
            rresp_r <= rd_hit ? gpc_pkg::RESP_OKAY : gpc_pkg::RESP_SLVERR;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Read decode; unmapped addresses read zero, except unaligned pin-form ones, which read that pin's word
    always_comb begin
        rd_hit = addr_hit(s_axi_araddr);
        rd_val = 32'h0000_0000;
        if (s_axi_araddr[7:5] == gpc_pkg::OFS_PIN_BASE[7:5]) begin
            wpin = s_axi_araddr[4:2];
            rd_val[7:0] = {bie_r[wpin], byp_r[wpin], slw_r[wpin], dm2_r[wpin], dm1_r[wpin],
                           dm0_r[wpin], pin_s2_r[wpin], port_output_value_r[wpin]};
        end else begin
            wpin = 3'h0;
            case (s_axi_araddr)
                gpc_pkg::OFS_OUT: rd_val[7:0] = port_output_value_r;
                gpc_pkg::OFS_DM0: rd_val[7:0] = dm0_r;
                gpc_pkg::OFS_DM1: rd_val[7:0] = dm1_r;
                gpc_pkg::OFS_DM2: rd_val[7:0] = dm2_r;
                gpc_pkg::OFS_SLW: rd_val[7:0] = slw_r;
                gpc_pkg::OFS_BYP: rd_val[7:0] = byp_r;
                gpc_pkg::OFS_BIE: rd_val[7:0] = bie_r;
                gpc_pkg::OFS_IBD: rd_val[7:0] = ibd_r;
                gpc_pkg::OFS_CTL: rd_val[1:0] = {hyst_r, lvttl_r};
                gpc_pkg::OFS_VREG: rd_val[7:0] = vreg_r;
                gpc_pkg::OFS_REF: rd_val[11:0] = ref_r;
                gpc_pkg::OFS_ITYPE: rd_val[15:0] = itype_r;
                gpc_pkg::OFS_ISTAT: rd_val[7:0] = istat_r;
                gpc_pkg::OFS_PSTATE: rd_val[7:0] = pin_s2_r;
                gpc_pkg::OFS_OESEL: rd_val = oesel_r;
                gpc_pkg::OFS_RSTCFG: rd_val[1:0] = rst_cfg_r;
                default: rd_val = 32'h0000_0000;
            endcase
        end
    end

    // Byte-lane mask of the pending write
    assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
    assign wd8 = wdata_r[7:0];
    assign wm8 = wmask[7:0];
    assign wr_pin = do_wr && (waddr_r[7:5] == gpc_pkg::OFS_PIN_BASE[7:5]);
    logic [2:0] wpin_w;
    assign wpin_w = waddr_r[4:2];

    // Configuration registers. Nothing here depends on a power mode, so the
    // whole setup simply holds through low-power periods until rewritten.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            port_output_value_r <= gpc_pkg::RST_BYTE;
            dm0_r <= gpc_pkg::RST_BYTE;
            dm1_r <= gpc_pkg::RST_BYTE;
            dm2_r <= gpc_pkg::RST_BYTE;
            slw_r <= gpc_pkg::RST_BYTE;
            byp_r <= gpc_pkg::RST_BYTE;
            bie_r <= gpc_pkg::RST_BYTE;
            ibd_r <= gpc_pkg::RST_BYTE;
            vreg_r <= gpc_pkg::RST_BYTE;
            lvttl_r <= 1'b0;
            hyst_r <= 1'b0;
            ref_r <= gpc_pkg::RST_REF;
            itype_r <= gpc_pkg::RST_ITYPE;
            oesel_r <= gpc_pkg::RST_OESEL;
            rst_cfg_r <= gpc_pkg::RCFG_HIZ;
            ld_done_r <= 1'b0;
        end else if (!ld_done_r) begin
            // First edge after release: apply stored reset pull setting
            ld_done_r <= 1'b1;
            rst_cfg_r <= nv_rst_cfg;
            if (nv_rst_cfg == gpc_pkg::RCFG_PULLUP) begin
                dm1_r <= gpc_pkg::ALL_ONES;
                port_output_value_r <= gpc_pkg::ALL_ONES;
            end else if (nv_rst_cfg == gpc_pkg::RCFG_PULLDN) begin
                dm0_r <= gpc_pkg::ALL_ONES;
                dm1_r <= gpc_pkg::ALL_ONES;
            end
        end else if (wr_pin) begin
            if (wstrb_r[0]) begin
                port_output_value_r[wpin_w] <= wd8[gpc_pkg::PF_OUT_BIT];
                dm0_r[wpin_w] <= wd8[gpc_pkg::PF_DM_LSB];
                dm1_r[wpin_w] <= wd8[gpc_pkg::PF_DM_LSB + 1];
                dm2_r[wpin_w] <= wd8[gpc_pkg::PF_DM_LSB + 2];
                slw_r[wpin_w] <= wd8[gpc_pkg::PF_SLW_BIT];
                byp_r[wpin_w] <= wd8[gpc_pkg::PF_BYP_BIT];
                bie_r[wpin_w] <= wd8[gpc_pkg::PF_BIE_BIT];
            end
        end else if (do_wr) begin
            case (waddr_r)
                gpc_pkg::OFS_OUT: port_output_value_r <= (port_output_value_r & ~wm8) | (wd8 & wm8);
                gpc_pkg::OFS_DM0: dm0_r <= (dm0_r & ~wm8) | (wd8 & wm8);
                gpc_pkg::OFS_DM1: dm1_r <= (dm1_r & ~wm8) | (wd8 & wm8);
                gpc_pkg::OFS_DM2: dm2_r <= (dm2_r & ~wm8) | (wd8 & wm8);
                gpc_pkg::OFS_SLW: slw_r <= (slw_r & ~wm8) | (wd8 & wm8);
                gpc_pkg::OFS_BYP: byp_r <= (byp_r & ~wm8) | (wd8 & wm8);
                gpc_pkg::OFS_BIE: bie_r <= (bie_r & ~wm8) | (wd8 & wm8);
                gpc_pkg::OFS_IBD: ibd_r <= (ibd_r & ~wm8) | (wd8 & wm8);
                gpc_pkg::OFS_CTL: begin
                    if (wstrb_r[0]) begin
                        lvttl_r <= wd8[gpc_pkg::CTL_LVTTL_BIT];
                        hyst_r <= wd8[gpc_pkg::CTL_HYST_BIT];
                    end
                end
                gpc_pkg::OFS_VREG: vreg_r <= (vreg_r & ~wm8) | (wd8 & wm8);
                gpc_pkg::OFS_REF: ref_r <= (ref_r & ~wmask[11:0]) | (wdata_r[11:0] & wmask[11:0]);
                gpc_pkg::OFS_ITYPE: itype_r <= (itype_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
                gpc_pkg::OFS_OESEL: oesel_r <= (oesel_r & ~wmask) | (wdata_r & wmask);
                default: ld_done_r <= 1'b1;
            endcase
        end
    end

    // Two-stage synchroniser, then a delayed copy for edge detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_s1_r <= gpc_pkg::RST_BYTE;
            pin_s2_r <= gpc_pkg::RST_BYTE;
            pin_prev_r <= gpc_pkg::RST_BYTE;
        end else begin
            pin_s1_r <= pin_in;
            pin_s2_r <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
        end
    end

    // Edge events only; a held level produces no further event
    genvar g;
    generate
        for (g = 0; g < gpc_pkg::PINS; g++) begin : g_pin
            logic [2:0] dm_g;
            logic data_g;
            logic oe_dyn_g;
            logic rise_g;
            logic fall_g;
            assign rise_g = pin_s2_r[g] && !pin_prev_r[g];
            assign fall_g = !pin_s2_r[g] && pin_prev_r[g];
            assign edge_set[g] = (rise_g && itype_r[2 * g + gpc_pkg::IT_RISE_BIT]) ||
                                 (fall_g && itype_r[2 * g + gpc_pkg::IT_FALL_BIT]);
            assign dm_g = {dm2_r[g], dm1_r[g], dm0_r[g]};
            assign data_g = byp_r[g] ? dsi_out[g] : port_output_value_r[g];
            assign oe_dyn_g = aux_oe[oesel_r[gpc_pkg::AUX_SEL_W * g +: gpc_pkg::AUX_SEL_W]];
            gpc_pin_drive u_drive (
                .pin_drive_mode_bits(dm_g),
                .data(data_g),
                .bie(bie_r[g]),
                .oe_dyn(oe_dyn_g),
                .vreg(vreg_r[g] && SIO_PORT),
                .ibd(ibd_r[g]),
                .slw(slw_r[g]),
                .drv_o(pin_out[g]),
                .drv_oe(pin_oe[g]),
                .pull_up(pin_pull_up[g]),
                .pull_dn(pin_pull_dn[g]),
                .in_en(pin_in_en[g]),
                .slow(pin_slew_select[g])
            );
        end
    endgenerate

    // Write-one-to-clear status; a new edge in the clear cycle still lands
    assign istat_clr = (do_wr && waddr_r == gpc_pkg::OFS_ISTAT) ? wd8 & wm8 : 8'h00;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            istat_r <= gpc_pkg::RST_BYTE;
        end else begin
            istat_r <= (istat_r & ~istat_clr) | edge_set;
        end
    end

    // One request line for the whole port; it needs only clk, which the
    // system keeps running in sleep so a pin edge can wake the device
    assign port_irq = |istat_r;

    // Port-level and special-pin controls from their registers, hysteresis and vreg gated by SIO_PORT; dsi_in from the synchroniser
    assign dsi_in = pin_s2_r;
    assign port_lvttl = lvttl_r;
    assign sio_hyst_en = hyst_r && SIO_PORT;
    assign pin_vreg_en = SIO_PORT ? vreg_r : 8'h00;
    assign sio_ref_sel = ref_r[7:0];
    assign sio_cmp_en = ref_r[gpc_pkg::REF_CMP_LSB +: gpc_pkg::SIO_PAIRS];

endmodule // gpc_port

// ===== tb/gpc_pin_world.sv
/* Pin model: resolves each pin from the port drive, pulls and an outside
   driver, and feeds it back. Runs on the bench clock. */
`timescale 1ns/1ps
module gpc_pin_world (
    input wire logic clk,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pull_up,
    input wire logic [7:0] pin_pull_dn,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_level
);
    logic [7:0] float_r = 8'h55;
    // A floating pin keeps flipping so no stale level can be trusted
    always_ff @(posedge clk) begin
        float_r <= ~float_r;
    end
    // Port drive wins, then the outside driver, then the pulls
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pin_pull_up | (~pin_pull_dn & float_r)));
endmodule // gpc_pin_world

// ===== tb/gpc_port_properties.sv
/* Checker for gpc_port: bus handshakes and pin stage relations.
   Sees only the port's own pins; bound to every gpc_port below. */
`timescale 1ns/1ps
module gpc_port_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pull_up,
    input wire logic [7:0] pin_pull_dn,
    input wire logic [7:0] pin_in_en,
    input wire logic [7:0] pin_slew_select,
    input wire logic [7:0] pin_vreg_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Address and data of one write taken at the same edge
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Values sampled at the release edge are still those held in reset
    a_reset_hiz: assert property ($rose(rst_n) |-> (pin_oe | pin_pull_up | pin_pull_dn | pin_in_en) == 8'h00)
        else $error("pin stage active in reset");
    a_pull_excl: assert property ((pin_oe & (pin_pull_up | pin_pull_dn)) == 8'h00 && (pin_pull_up & pin_pull_dn) == 8'h00)
        else $error("pull overlaps drive");
    a_pull_follows: assert property (((pin_pull_up & ~pin_out) | (pin_pull_dn & pin_out)) == 8'h00)
        else $error("pull against data");
    a_vreg_nopull: assert property ((pin_vreg_en & (pin_pull_up | pin_pull_dn)) == 8'h00)
        else $error("pull with regulated output");
    a_slew_nopull: assert property ((pin_slew_select & (pin_pull_up | pin_pull_dn)) == 8'h00)
        else $error("slow slew in resistive mode");
    a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answering");
endmodule // gpc_port_chk

bind gpc_port gpc_port_chk u_chk (.*);

// ===== tb/tb.sv
/* Bench for gpc_port: AXI4-Lite register tasks and pin tests.
   Needs gpc_pkg, the pin model and the checker compiled first. */
`timescale 1ns/1ps
module tb;
    localparam logic [7:0] D1_OE = 8'h68, D0_OE = 8'h54, D1_PU = 8'h84, D0_PD = 8'h88, SLOW = 8'h70;
    logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b1, arv = 1'b0, rrdy = 1'b1;
    logic awr, wr_rdy, bv, arr, rv, lvttl, hyst, irq;
    logic [1:0] bresp, rresp, nv = gpc_pkg::RCFG_PULLUP;
    logic [3:0] cmp;
    logic [7:0] awa = 8'h00, ara = 8'h00, ext_en = 8'h00, ext_val = 8'h00, dsi = 8'h00;
    logic [7:0] pin_in, pout, oe, pu, pd, ien, slw, vreg, rsel, dsin;
    logic [15:0] aux = 16'h0000;
    logic [31:0] wd = 32'h0, rdata;
    int errors = 0, total_checks = 0, cycles = 0;
    gpc_port dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
        .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy), .pin_in(pin_in),
        .pin_out(pout), .pin_oe(oe), .pin_pull_up(pu), .pin_pull_dn(pd), .pin_in_en(ien), .pin_slew_select(slw),
        .pin_vreg_en(vreg), .port_lvttl(lvttl), .sio_hyst_en(hyst), .sio_ref_sel(rsel), .sio_cmp_en(cmp),
        .aux_oe(aux), .dsi_out(dsi), .dsi_in(dsin), .nv_rst_cfg(nv), .port_irq(irq));
    gpc_pin_world world (.clk(clk), .pin_out(pout), .pin_oe(oe), .pin_pull_up(pu), .pin_pull_dn(pd),
        .ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_in));
    always #5 clk = ~clk;
    // The run needs about two hundred cycles; a hang ends it as a failure
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            test_done();
        end
    end
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic chk8(input string n, input logic [7:0] s, input logic [7:0] e);
        check(n, {24'h0, s}, {24'h0, e});
    endtask
    // Requests rise after an edge and hold until ready is seen at an edge; bready and rready stay high,
    // so the answer is taken at the very edge that completes its handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input bit bad = 1'b0);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr_rdy) wv <= 1'b0;
        end while (!bv);
        check("bresp", {30'h0, bresp}, {30'h0, bad ? gpc_pkg::RESP_SLVERR : gpc_pkg::RESP_OKAY});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ex, input bit bad = 1'b0);
        ara <= a;
        arv <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
        check("rdata", rdata, ex);
        check("rresp", {30'h0, rresp}, {30'h0, bad ? gpc_pkg::RESP_SLVERR : gpc_pkg::RESP_OKAY});
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Main sequence: reset, drive modes, pin form, interrupts, controls, faults
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(negedge clk);
        chk8("pull_up", pu, 8'hFF);
        @(posedge clk);
        rd(8'h08, 32'hFF);
        $display("reset test done");
        wr(8'h00, 32'h0F);
        wr(8'h10, 32'hFF);
        for (int m = 0; m < 8; m++) begin
            wr(8'h04, {24'h0, {8{m[0]}}});
            wr(8'h08, {24'h0, {8{m[1]}}});
            wr(8'h0C, {24'h0, {8{m[2]}}});
            chk8("oe", oe, (D1_OE[m] ? 8'h0F : 8'h00) | (D0_OE[m] ? 8'hF0 : 8'h00));
            chk8("pull_up", pu, D1_PU[m] ? 8'h0F : 8'h00);
            chk8("pull_dn", pd, D0_PD[m] ? 8'hF0 : 8'h00);
            chk8("in_en", ien, (m == 0) ? 8'h00 : 8'hFF);
            chk8("slew", slw, SLOW[m] ? 8'hFF : 8'h00);
        end
        $display("drive mode test done");
        wr(8'h04, 32'hFF);
        wr(8'h08, 32'h0);
        wr(8'h0C, 32'h0);
        wr(8'h00, 32'h0);
        wr(8'h4C, 32'h19);
        chk8("oe", oe, 8'h08);
        rd(8'h04, 32'hF7);
        wr(8'h18, 32'h08);
        wr(8'h38, 32'hF000);
        chk8("oe", oe, 8'h00);
        aux <= 16'h8000;
        dsi <= 8'hF7;
        @(negedge clk);
        chk8("oe", oe, 8'h08);
        @(posedge clk);
        wr(8'h14, 32'h08);
        chk8("out", pout, 8'h00);
        wr(8'h1C, 32'hFF);
        chk8("in_en", ien, 8'h00);
        wr(8'h1C, 32'h0);
        $display("pin form and bidirectional test done");
        ext_en <= 8'hF7;
        wr(8'h2C, 32'h39);
        wr(8'h30, 32'hFF);
        ext_val <= 8'h17;
        repeat (8) @(posedge clk);
        rd(8'h30, 32'h05);
        chk8("irq", {7'h0, irq}, 8'h01);
        wr(8'h30, 32'hFF);
        repeat (8) @(posedge clk);
        rd(8'h30, 32'h0);
        ext_val <= 8'h00;
        repeat (8) @(posedge clk);
        rd(8'h30, 32'h06);
        $display("interrupt test done");
        wr(8'h20, 32'h3);
        chk8("ctl", {6'h0, hyst, lvttl}, 8'h03);
        wr(8'h28, 32'h5E4);
        chk8("ref", rsel, 8'hE4);
        chk8("cmp", {4'h0, cmp}, 8'h05);
        wr(8'h14, 32'h0);
        wr(8'h04, 32'h0);
        wr(8'h08, 32'hFF);
        wr(8'h00, 32'hFF);
        // Pin 3 still carries strong mode from its pin-form write, so it shows no pull
        chk8("pull_up", pu, 8'hF7);
        wr(8'h24, 32'hFF);
        chk8("pull_up", pu, 8'h00);
        chk8("vreg", vreg, 8'hFF);
        // Overvoltage use: open drain low with data high, the outside pulls every pin up
        ext_en <= 8'hFF;
        ext_val <= 8'hFF;
        wr(8'h08, 32'h0);
        wr(8'h0C, 32'hFF);
        chk8("oe", oe, 8'h00);
        chk8("dsi_in", dsin, 8'hFF);
        rd(8'h34, 32'hFF);
        rd(8'h60, 32'h0, 1'b1);
        wr(8'h62, 32'hFF, 1'b1);
        $display("control and fault test done");
        // Second reset with the stored setting changed to pull-down
        nv <= gpc_pkg::RCFG_PULLDN;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        chk8("pull_dn", pd, 8'hFF);
        rd(8'h3C, 32'h2);
        $display("reload test done");
        test_done();
    end
endmodule // tb
